// File: inc/timer_half_pkg.sv
// Purpose: shared constants and types for one timer half
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are word aligned
package timer_half_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_GLOBAL_CONFIG = 8'h00;
  localparam logic [7:0] OFF_HALF_MODE = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h20;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h24;
  localparam logic [7:0] OFF_INTERVAL_LOAD = 8'h28;
  localparam logic [7:0] OFF_MATCH_VALUE = 8'h30;
  localparam logic [7:0] OFF_PRESCALE = 8'h38;
  localparam logic [7:0] OFF_TIMER_VALUE = 8'h48;
  // global config values
  localparam logic [2:0] CFG_32_PERIODIC = 3'h0;
  localparam logic [2:0] CFG_32_RTC = 3'h1;
  localparam logic [2:0] CFG_16_SPLIT = 3'h4;
  // timer mode field values
  localparam logic [1:0] TMODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] TMODE_PERIODIC = 2'h2;
  localparam logic [1:0] TMODE_CAPTURE = 2'h3;
  // half mode register fields
  localparam int MODE_TMR_LSB = 0;
  localparam int MODE_CMR_BIT = 2;
  localparam int MODE_AMS_BIT = 3;
  // control register fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_EVENT_LSB = 2;
  localparam int CTL_RTC_BIT = 4;
  localparam int CTL_INV_BIT = 6;
  // status bit positions (raw, mask, clear share them)
  localparam int ST_TIMEOUT = 0;
  localparam int ST_MATCH = 1;
  localparam int ST_CAPTURE = 2;
  localparam int ST_RTC = 3;
  // edge select encodings
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // reset, zero-compare, rtc start and rtc roll values
  localparam logic [15:0] LOAD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [31:0] RTC_START = 32'h0000_0001;
  localparam logic [31:0] RTC_ROLL = 32'h0000_0000;
  // operating modes of the half
  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_ONE_SHOT = 3'b001,
    OP_PERIODIC = 3'b010,
    OP_EDGE_COUNT = 3'b011,
    OP_EDGE_TIME = 3'b100,
    OP_PWM = 3'b101,
    OP_RTC = 3'b110
  } op_mode_t;
  // decoded control fields
  typedef struct packed {
    logic run;
    logic [1:0] edge_select;
    logic rtc_stall_override;
    logic pwm_output_invert;
  } ctl_t;
endpackage : timer_half_pkg

// File: rtl/timer_half.sv
// Purpose: one timer half: 16-bit periodic/one-shot, edge count, edge time, pwm, 32-bit rtc
// Assumes: classic wishbone slave, one clock, synchronous active high reset
// Notes: the 32-bit one-shot/periodic runs on this half's 16-bit datapath
//
// Contract
// R01: source holds new level two clocks
// R02: prescaler bypassed in capture and pwm
// R03: mode select 0 counts chosen edges
// R04: each qualifying edge decrements counter
// R05: match sets raw and masked flags
// R06: on match reload, stop, ignore edges
// R07: edge time free-runs from load, one edge
// R08: selected edge captures count, sets flags
// R09: edge time keeps counting, reloads at zero
// R10: captured value held until next edge
// R11: pwm mode entered by mode fields
// R12: pwm counts to zero then reloads
// R13: pwm never sets status flags
// R14: pwm high at load, low at match
// R15: invert bit flips pwm polarity
// R16: software stops timer before reconfiguring
// R17: global config selects 32, rtc, 16
// R18: mode field one-shot stops, periodic continues
// R19: write one clears raw and masked
// R20: rtc needs 32.768 kHz on pin
// R21: rtc match rolls to zero, continues
// R22: prescaler extends count in 16-bit modes
// R23: pin synchronised, edges from sample pairs
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module timer_half
  import timer_half_pkg::*;
#(
  parameter int RTC_DIVIDE = 32768
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_compare_pin_i,
  output logic capture_compare_pin_o,
  output logic capture_compare_pin_oe
);
  if (RTC_DIVIDE < 2 || RTC_DIVIDE > 65536) begin : g_bad_divide
    $error("RTC_DIVIDE out of range");
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] global_config_reg, next_global_config_reg;
  logic [3:0] half_mode_reg, next_half_mode_reg;
  ctl_t control_reg, next_control_reg;
  logic [3:0] interrupt_mask_reg, next_interrupt_mask_reg;
  logic [3:0] raw_status_reg, next_raw_status_reg;
  logic [15:0] interval_load_reg, next_interval_load_reg;
  logic [31:0] match_value_reg, next_match_value_reg;
  logic [7:0] prescale_reg, next_prescale_reg;
  logic [15:0] timer_value_reg, next_timer_value_reg;
  logic [15:0] count, next_count;
  logic [7:0] pre_count, next_pre_count;
  logic [31:0] rtc_count, next_rtc_count;
  logic [15:0] rtc_div, next_rtc_div;
  logic rtc_started, next_rtc_started;
  logic pwm_level, next_pwm_level;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic sync1, sync2, sync3;
  op_mode_t op;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge; unselected lanes keep old bits, except on the control word where they write zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = dat[i*8 +: 8];
    end
    return r;
  endfunction : merge
  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  // sync1 only feeds sync2; edges come from sync2/sync3 pairs
  always_ff @(posedge clk) begin
    sync1 <= capture_compare_pin_i;
    sync2 <= sync1;
    sync3 <= sync2; // [R23]
  end
  logic rise, fall, edge_hit;
  assign rise = sync2 & ~sync3;
  assign fall = ~sync2 & sync3;
  // narrow pulses under two clocks may be missed entirely [R01]
  always_comb begin
    case (control_reg.edge_select)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = (op == OP_EDGE_COUNT) ? (rise | fall) : rise; // [R03] [R07]
      default: edge_hit = rise;
    endcase
  end
  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    op = OP_IDLE;
    if (global_config_reg == CFG_32_RTC) begin
      op = OP_RTC; // [R17]
    end else if (global_config_reg == CFG_16_SPLIT || global_config_reg == CFG_32_PERIODIC) begin
      if (half_mode_reg[MODE_AMS_BIT] && !half_mode_reg[MODE_CMR_BIT] &&
          half_mode_reg[1:0] == TMODE_PERIODIC) begin
        op = OP_PWM; // [R11]
      end else if (half_mode_reg[1:0] == TMODE_ONE_SHOT) begin
        op = OP_ONE_SHOT; // [R18]
      end else if (half_mode_reg[1:0] == TMODE_PERIODIC) begin
        op = OP_PERIODIC; // [R18]
      end else if (half_mode_reg[1:0] == TMODE_CAPTURE) begin
        op = half_mode_reg[MODE_CMR_BIT] ? OP_EDGE_TIME : OP_EDGE_COUNT;
      end
    end
  end
  // ----------------------------------------------------------------
  // bus decode and register writes
  // ----------------------------------------------------------------
  logic req, wr, auto_stop;
  assign req = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = req & wb_we_i;
  logic [31:0] clear_bits, wr_word;
  assign wr_word = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  // write-one-to-clear of status; hardware set wins below
  assign clear_bits = (wr && wb_adr_i == OFF_INT_CLEAR) ? wr_word : 32'h0000_0000; // [R19]

  always_comb begin
    next_ack = req;
    next_rdata = rdata;
    next_global_config_reg = global_config_reg;
    next_half_mode_reg = half_mode_reg;
    next_interrupt_mask_reg = interrupt_mask_reg;
    next_interval_load_reg = interval_load_reg;
    next_match_value_reg = match_value_reg;
    next_prescale_reg = prescale_reg;
    next_control_reg = control_reg;
    if (wr) begin
      if (wb_adr_i == OFF_GLOBAL_CONFIG) begin
        next_global_config_reg = 3'(merge({29'h0, global_config_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == OFF_HALF_MODE) begin
        next_half_mode_reg = 4'(merge({28'h0, half_mode_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == OFF_CONTROL) begin
        next_control_reg = ctl_t'({wr_word[CTL_EN_BIT], wr_word[CTL_EVENT_LSB +: 2],
                                   wr_word[CTL_RTC_BIT], wr_word[CTL_INV_BIT]});
      end else if (wb_adr_i == OFF_INT_MASK) begin
        next_interrupt_mask_reg = 4'(merge({28'h0, interrupt_mask_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == OFF_INTERVAL_LOAD) begin
        next_interval_load_reg = 16'(merge({16'h0, interval_load_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == OFF_MATCH_VALUE) begin
        next_match_value_reg = merge(match_value_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFF_PRESCALE) begin
        next_prescale_reg = 8'(merge({24'h0, prescale_reg}, wb_dat_i, wb_sel_i));
      end
    end else if (req) begin
      // unmapped reads return zero
      if (wb_adr_i == OFF_GLOBAL_CONFIG) next_rdata = {29'h0, global_config_reg};
      else if (wb_adr_i == OFF_HALF_MODE) next_rdata = {28'h0, half_mode_reg};
      else if (wb_adr_i == OFF_CONTROL) next_rdata = {25'h0, control_reg.pwm_output_invert, 1'b0,
                                                   control_reg.rtc_stall_override,
                                                   control_reg.edge_select, 1'b0, control_reg.run};
      else if (wb_adr_i == OFF_INT_MASK) next_rdata = {28'h0, interrupt_mask_reg};
      else if (wb_adr_i == OFF_RAW_STATUS) next_rdata = {28'h0, raw_status_reg};
      else if (wb_adr_i == OFF_MASKED_STATUS) next_rdata = {28'h0, raw_status_reg & interrupt_mask_reg};
      else if (wb_adr_i == OFF_INTERVAL_LOAD) next_rdata = {16'h0, interval_load_reg};
      else if (wb_adr_i == OFF_MATCH_VALUE) next_rdata = match_value_reg;
      else if (wb_adr_i == OFF_PRESCALE) next_rdata = {24'h0, prescale_reg};
      else if (wb_adr_i == OFF_TIMER_VALUE) next_rdata = (op == OP_RTC) ? rtc_count
                                                                      : {16'h0, timer_value_reg};
      else next_rdata = 32'h0000_0000;
    end
    // a hardware stop beats a software write of the control word [R06] [R18]
    if (auto_stop) next_control_reg.run = 1'b0;
  end
  // ----------------------------------------------------------------
  // counter engine
  // ----------------------------------------------------------------
  logic run, step, at_zero, at_match, rtc_tick;
  assign run = control_reg.run;
  assign at_zero = (count == COUNT_ZERO);
  assign at_match = (count == match_value_reg[15:0]);
  assign rtc_tick = (rtc_div == 16'(RTC_DIVIDE - 1)) & edge_hit;
  // prescale only in one-shot/periodic; capture and pwm step every event or clock [R02]
  assign step = (op == OP_ONE_SHOT || op == OP_PERIODIC) ? (pre_count == PRESCALE_RESET) : 1'b1; // [R22]
  assign auto_stop = run && ((op == OP_ONE_SHOT && step && at_zero) ||
                             (op == OP_EDGE_COUNT && at_match)); // [R06] [R18]

  always_comb begin
    next_count = count;
    next_pre_count = pre_count;
    next_timer_value_reg = timer_value_reg;
    next_raw_status_reg = raw_status_reg & ~clear_bits[3:0];
    next_rtc_count = rtc_count;
    next_rtc_div = rtc_div;
    next_rtc_started = rtc_started;
    next_pwm_level = pwm_level;
    if (run) begin
      case (op)
        OP_ONE_SHOT, OP_PERIODIC: begin
          next_pre_count = (pre_count == PRESCALE_RESET) ? prescale_reg : pre_count - 8'h01;
          if (step) begin
            if (at_zero) begin
              next_count = interval_load_reg;
              next_raw_status_reg[ST_TIMEOUT] = 1'b1;
            end else begin
              next_count = count - 16'h0001;
            end
          end
          next_timer_value_reg = next_count;
        end
        OP_EDGE_COUNT: begin
          if (edge_hit) begin
            next_count = count - 16'h0001; // [R04]
          end
          if (at_match) begin
            next_raw_status_reg[ST_MATCH] = 1'b1; // [R05]
            next_count = interval_load_reg; // [R06]
          end
          next_timer_value_reg = next_count;
        end
        OP_EDGE_TIME: begin
          next_count = at_zero ? interval_load_reg : count - 16'h0001; // [R09]
          if (edge_hit) begin
            next_timer_value_reg = count; // [R08] [R10]
            next_raw_status_reg[ST_CAPTURE] = 1'b1; // [R08]
          end
        end
        OP_PWM: begin // no status flag is touched in pwm [R13]
          next_count = at_zero ? interval_load_reg : count - 16'h0001; // [R12]
          if (count == interval_load_reg) next_pwm_level = 1'b1; // [R14]
          else if (at_match) next_pwm_level = 1'b0; // [R14]
          next_timer_value_reg = next_count;
        end
        OP_RTC: begin
          // rtc_stall_override: no stall input exists here, so the bit is storage only
          if (!rtc_started) begin
            next_rtc_count = RTC_START;
            next_rtc_started = 1'b1;
          end else if (edge_hit) begin
            next_rtc_div = rtc_tick ? 16'h0000 : rtc_div + 16'h0001; // [R20]
            if (rtc_tick) begin
              if (rtc_count == match_value_reg) begin
                next_rtc_count = RTC_ROLL; // [R21]
                next_raw_status_reg[ST_RTC] = 1'b1;
              end else begin
                next_rtc_count = rtc_count + 32'h0000_0001;
              end
            end
          end
        end
        default: ;
      endcase
    end else begin
      next_pre_count = prescale_reg;
      next_count = interval_load_reg; // edge time starts from load too [R07]
      next_pwm_level = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      global_config_reg <= 3'h0;
      half_mode_reg <= 4'h0;
      control_reg <= '0;
      interrupt_mask_reg <= 4'h0;
      raw_status_reg <= 4'h0;
      interval_load_reg <= LOAD_RESET;
      match_value_reg <= {16'h0000, LOAD_RESET};
      prescale_reg <= PRESCALE_RESET;
      timer_value_reg <= LOAD_RESET;
      count <= LOAD_RESET;
      pre_count <= PRESCALE_RESET;
      rtc_count <= RTC_ROLL;
      rtc_div <= 16'h0000;
      rtc_started <= 1'b0;
      pwm_level <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      global_config_reg <= next_global_config_reg;
      half_mode_reg <= next_half_mode_reg;
      control_reg <= next_control_reg;
      interrupt_mask_reg <= next_interrupt_mask_reg;
      raw_status_reg <= next_raw_status_reg;
      interval_load_reg <= next_interval_load_reg;
      match_value_reg <= next_match_value_reg;
      prescale_reg <= next_prescale_reg;
      timer_value_reg <= next_timer_value_reg;
      count <= next_count;
      pre_count <= next_pre_count;
      rtc_count <= next_rtc_count;
      rtc_div <= next_rtc_div;
      rtc_started <= (op == OP_RTC) ? next_rtc_started : 1'b0;
      pwm_level <= next_pwm_level;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  // pin is driven only in pwm mode; otherwise it is an input
  assign capture_compare_pin_oe = (op == OP_PWM);
  assign capture_compare_pin_o = (op == OP_PWM) & (pwm_level ^ control_reg.pwm_output_invert); // [R15]
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_count_step;
      (run && op == OP_EDGE_COUNT && edge_hit && !at_match) |=> count == $past(count) - 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("edge did not decrement"); // [R04]
  property p_match_flag;
      (run && op == OP_EDGE_COUNT && at_match) |=> raw_status_reg[ST_MATCH];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // [R05]
  property p_match_stop;
      (run && op == OP_EDGE_COUNT && at_match) |=> !run && count == $past(interval_load_reg);
  endproperty
  a_match_stop: assert property (p_match_stop) else $error("no stop after match"); // [R06]
  property p_capture;
      (run && op == OP_EDGE_TIME && edge_hit) |=> timer_value_reg == $past(count)
        && raw_status_reg[ST_CAPTURE];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed"); // [R08]
  property p_hold;
      (op == OP_EDGE_TIME && !edge_hit && !wr) |=> $stable(timer_value_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("capture not held"); // [R10]
  property p_reload;
      (run && (op == OP_EDGE_TIME || op == OP_PWM) && at_zero) |=> count == $past(interval_load_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero"); // [R09]
  property p_pwm_quiet;
      (op == OP_PWM && !wr) |=> raw_status_reg == ($past(raw_status_reg) & ~$past(clear_bits[3:0]));
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("flag set in pwm"); // [R13]
  property p_pwm_high;
      (run && op == OP_PWM && count == interval_load_reg && !wr)
        |=> capture_compare_pin_o == !control_reg.pwm_output_invert;
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("pwm level wrong"); // [R14]
  property p_clear;
      (clear_bits[ST_MATCH] && !(run && op == OP_EDGE_COUNT && at_match))
        |=> !raw_status_reg[ST_MATCH];
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored"); // [R19]
  c_edge_count: cover property (@(posedge clk) run && op == OP_EDGE_COUNT && at_match);
  c_edge_time: cover property (@(posedge clk) run && op == OP_EDGE_TIME && edge_hit);
  c_pwm: cover property (@(posedge clk) op == OP_PWM && run && at_zero);
endmodule : timer_half

// File: verification/edge_source.sv
// Purpose: far-side model, a signal source on the capture pin
// Assumes: the device drives the pin only while its enable is high
// Notes: hold is an argument so that fast and slow sources are both tried
`timescale 1ns/1ps
module edge_source (
  input wire logic clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i
);
  logic level = 1'b0;
  // wire level: the device wins while it drives, else the source
  assign pin_i = pin_oe ? pin_o : level;
  // one toggle is one edge; stands in for the slow rtc clock, scaled down
  task automatic toggle(input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      level <= ~level;
      repeat ((hold < 2) ? 2 : hold) @(posedge clk); // new level held at least two clocks
    end
    // let the three-clock sync and detect path settle before the bench looks
    repeat (4) @(posedge clk);
  endtask : toggle
endmodule : edge_source

// File: verification/timer_capture_pwm_modes_tb_top.sv
// Purpose: register-level tests of one timer half
// Assumes: wishbone ack one cycle after the request is taken
// Notes: rtc divide shortened to 4 selected edges
`timescale 1ns/1ps
module timer_capture_pwm_modes_tb_top;
  import timer_half_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [31:0] v1;
  logic ack, pin_i, pin_o, pin_oe;
  int err_count = 0;
  int checks = 0;
  always #25 clk = ~clk;
  timer_half #(.RTC_DIVIDE(4)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .capture_compare_pin_i(pin_i),
    .capture_compare_pin_o(pin_o), .capture_compare_pin_oe(pin_oe));
  edge_source src_u (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) chk(32'h0, 32'h1);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  // bounded poll of one raw status bit
  task automatic poll(input int b);
    int i;
    i = 0;
    xfer(1'b0, OFF_RAW_STATUS, 32'h0);
    while (rdat[b] !== 1'b1 && i < 60) begin
      xfer(1'b0, OFF_RAW_STATUS, 32'h0);
      i++;
    end
    chk({31'h0, rdat[b]}, 32'h1);
  endtask : poll
  // high samples over ten whole periods of load 9
  task automatic pwm_run(input logic [31:0] ctl, input int exp_high);
    int h;
    h = 0;
    wr(OFF_CONTROL, 32'h0); // stop before changing polarity
    wr(OFF_CONTROL, ctl);
    repeat (20) @(posedge clk);
    repeat (100) begin
      @(negedge clk);
      if (pin_o === 1'b1) h++;
    end
    chk(h, exp_high);
    chk({31'h0, pin_oe}, 32'h1);
  endtask : pwm_run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // watchdog: the tests need well under 8000 clocks
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(OFF_INTERVAL_LOAD, 32'h0000_FFFF);
    rd(OFF_MATCH_VALUE, 32'h0000_FFFF);
    rd(OFF_PRESCALE, 32'h0);
    rd(OFF_TIMER_VALUE, 32'h0000_FFFF);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0);
    $display("test reset done");
    wr(OFF_GLOBAL_CONFIG, 32'h4);
    rd(OFF_GLOBAL_CONFIG, 32'h4);
    wr(OFF_HALF_MODE, 32'h3);
    wr(OFF_CONTROL, 32'hC);
    wr(OFF_INTERVAL_LOAD, 32'hA);
    wr(OFF_MATCH_VALUE, 32'h6);
    wr(OFF_INT_MASK, 32'h2);
    wr(OFF_CONTROL, 32'hD);
    src_u.toggle(3, 2);
    rd(OFF_RAW_STATUS, 32'h0);
    src_u.toggle(1, 2);
    rd(OFF_RAW_STATUS, 32'h2);
    rd(OFF_MASKED_STATUS, 32'h2);
    rd(OFF_CONTROL, 32'hC);
    src_u.toggle(2, 5);
    rd(OFF_TIMER_VALUE, 32'hA);
    wr(OFF_INT_CLEAR, 32'h0);
    rd(OFF_RAW_STATUS, 32'h2);
    wr(OFF_INT_CLEAR, 32'h2);
    rd(OFF_RAW_STATUS, 32'h0);
    rd(OFF_MASKED_STATUS, 32'h0);
    $display("test edge count done");
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_HALF_MODE, 32'h7);
    wr(OFF_INTERVAL_LOAD, 32'h0FFF);
    wr(OFF_INT_MASK, 32'h4);
    wr(OFF_CONTROL, 32'h1);
    src_u.toggle(2, 3);
    xfer(1'b0, OFF_TIMER_VALUE, 32'h0);
    v1 = rdat;
    rd(OFF_TIMER_VALUE, v1);
    chk({31'h0, v1 < 32'h0FFF && v1 > 32'h0FF0}, 32'h1);
    rd(OFF_RAW_STATUS, 32'h4);
    rd(OFF_MASKED_STATUS, 32'h4);
    src_u.toggle(2, 3);
    xfer(1'b0, OFF_TIMER_VALUE, 32'h0);
    chk({31'h0, rdat < v1}, 32'h1);
    wr(OFF_INT_CLEAR, 32'h4);
    $display("test edge time done");
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_HALF_MODE, 32'hA);
    wr(OFF_INTERVAL_LOAD, 32'h9);
    wr(OFF_MATCH_VALUE, 32'h3);
    pwm_run(32'h1, 60);
    pwm_run(32'h41, 40);
    rd(OFF_RAW_STATUS, 32'h0);
    $display("test pwm done");
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_HALF_MODE, 32'h1);
    wr(OFF_PRESCALE, 32'h3);
    rd(OFF_PRESCALE, 32'h3);
    wr(OFF_INTERVAL_LOAD, 32'h5);
    wr(OFF_INT_MASK, 32'h1);
    wr(OFF_CONTROL, 32'h1);
    poll(ST_TIMEOUT);
    rd(OFF_CONTROL, 32'h0);
    wr(OFF_INT_CLEAR, 32'h1);
    wr(OFF_HALF_MODE, 32'h2);
    wr(OFF_CONTROL, 32'h1);
    poll(ST_TIMEOUT);
    wr(OFF_INT_CLEAR, 32'h1);
    poll(ST_TIMEOUT);
    rd(OFF_CONTROL, 32'h1);
    $display("test one-shot periodic done");
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_INT_CLEAR, 32'hF);
    wr(OFF_GLOBAL_CONFIG, 32'h1);
    rd(OFF_GLOBAL_CONFIG, 32'h1);
    wr(OFF_MATCH_VALUE, 32'h2);
    wr(OFF_INT_MASK, 32'h8);
    wr(OFF_CONTROL, 32'h1);
    src_u.toggle(8, 2);
    rd(OFF_TIMER_VALUE, 32'h2);
    rd(OFF_RAW_STATUS, 32'h0);
    src_u.toggle(8, 2);
    rd(OFF_RAW_STATUS, 32'h8);
    src_u.toggle(8, 2);
    rd(OFF_TIMER_VALUE, 32'h1);
    $display("test rtc done");
    test_done();
  end
endmodule : timer_capture_pwm_modes_tb_top
